// [verilog/dcrm_handler.sv]
// Mailbox command handler for record level disc file work
// Notes on behaviour
// - overwriting a record truncates every later record
// - write is parameters then code 89h
// - write answers 00 or an error code
// - pointer advances after every successful write
// - code 82h closes file, answers result
// - open takes type and disc, answers result
// - first access to a file selects record 1
// - advance moves pointer forward or errors
// - backup moves pointer backward or errors
// - position sets pointer absolutely or errors
// - rewind selects record 1 or errors
// - read writes the bytes, then the count, then answers 00
// - rename only changes the bound name
// - command byte is polled periodically
// - record work on closed file answers 09
`timescale 1ns/100ps
module dcrm_handler (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Mailbox configuration
	input  wire logic [15:0] slotBase,
	// Mailbox memory port, read data one cycle after the strobe
	output logic      [15:0] mbAddr,
	output logic             mbRe,
	output logic             mbWe,
	output logic      [7:0]  mbWrData,
	input  wire logic [7:0]  mbRdData,
	// File status
	output logic             fileOpen,
	output logic      [7:0]  fileType,
	output logic      [7:0]  discNumber,
	output logic      [14:0] curRecord,
	output logic      [14:0] lastRecord,
	// Command status
	output logic             busy,
	output logic             cmdDone,
	output logic      [7:0]  cmdResult,
	// Bound name
	output logic      [127:0] nameRecord,
	output logic             nameUpdated
);
	import dcrm_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE, S_WAIT, S_GET_CMD, S_GET_P1, S_GET_P2, S_EXEC, S_WR_CAP,
		S_RD_FETCH, S_RD_HI, S_RD_LO, S_RD_CNT, S_NM_CAP, S_FINISH
	} dcrm_state_t;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	dcrm_state_t  state, next_state, retState, next_retState;
	logic [7:0]   cmd, next_cmd, p1, next_p1, p2, next_p2;
	logic [8:0]   idx, next_idx;
	logic [7:0]   hiByte, next_hiByte, xferLen, next_xferLen;
	logic [7:0]   next_cmdResult, next_mbWrData;
	logic [15:0]  next_mbAddr;
	logic         next_mbRe, next_mbWe, next_cmdDone, next_nameUpdated;
	logic         next_fileOpen;
	logic [7:0]   next_fileType, next_discNumber;
	logic [14:0]  next_curRecord, next_lastRecord;
	logic [127:0] nameBuf, next_nameBuf, next_nameRecord;

	// Record store hookup
	logic                      pollTick;
	logic                      stWordWe, stLenWe;
	logic [15:0]               stRdData;
	logic [7:0]                stLenRd;
	logic [REC_AW-1:0]         recIdx;
	logic [REC_AW+WORD_AW-1:0] stAddr;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	logic [14:0] count15;
	logic [15:0] advSum;
	logic [8:0]  wrLastByte, rdLastByte;
	logic        cmdValid;

	assign count15    = {p2[6:0], p1};
	assign advSum     = {1'b0, curRecord} + {1'b0, count15};
	assign wrLastByte = {p1, 1'b0} - 9'h001;
	assign rdLastByte = {xferLen, 1'b0} - 9'h001;
	assign recIdx     = REC_AW'(curRecord - FIRST_REC);
	assign stAddr     = {recIdx, idx[WORD_AW:1]};
	assign cmdValid   = mbRdData[CMD_REQ_BIT];

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	dcrm_poll_timer u_poll (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.pollTick (pollTick)
	);

	dcrm_rec_store u_store (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.wordWe     (stWordWe),
		.wordAddr   (stAddr),
		.wordWrData ({hiByte, mbRdData}),
		.wordRdData (stRdData),
		.lenWe      (stLenWe),
		.lenIdx     (recIdx),
		.lenWrData  (p1),
		.lenRdData  (stLenRd)
	);

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	// Next values of the whole sequencer and file state
	always_comb begin
		next_state = state;
		next_retState = retState;
		next_cmd = cmd;
		next_p1 = p1;
		next_p2 = p2;
		next_idx = idx;
		next_hiByte = hiByte;
		next_xferLen = xferLen;
		next_cmdResult = cmdResult;
		next_mbAddr = mbAddr;
		next_mbWrData = mbWrData;
		next_mbRe = 1'b0;
		next_mbWe = 1'b0;
		next_cmdDone = 1'b0;
		next_nameUpdated = 1'b0;
		next_fileOpen = fileOpen;
		next_fileType = fileType;
		next_discNumber = discNumber;
		next_curRecord = curRecord;
		next_lastRecord = lastRecord;
		next_nameBuf = nameBuf;
		next_nameRecord = nameRecord;
		stWordWe = 1'b0;
		stLenWe = 1'b0;
		unique case (state)
			S_IDLE: begin
				if (pollTick) begin
					next_mbRe = 1'b1;
					next_mbAddr = slotBase + OFS_CMD;
					next_retState = S_GET_CMD;
					next_state = S_WAIT;
				end
			end
			S_WAIT: begin
				next_state = retState;
			end
			S_GET_CMD: begin
				if (cmdValid) begin
					next_cmd = mbRdData;
					next_mbRe = 1'b1;
					next_mbAddr = slotBase + OFS_P1;
					next_retState = S_GET_P1;
					next_state = S_WAIT;
				end else begin
					next_state = S_IDLE;
				end
			end
			S_GET_P1: begin
				next_p1 = mbRdData;
				next_mbRe = 1'b1;
				next_mbAddr = slotBase + OFS_P2;
				next_retState = S_GET_P2;
				next_state = S_WAIT;
			end
			S_GET_P2: begin
				next_p2 = mbRdData;
				next_state = S_EXEC;
			end
			S_EXEC: begin
				next_idx = 9'h000;
				next_cmdResult = RES_OK;
				next_state = S_FINISH;
				if (cmd == CMD_OPEN) begin
					if (fileOpen) begin
						next_cmdResult = ERR_NOT_OPEN;
					end else begin
						next_fileOpen = 1'b1;
						next_fileType = p1;
						next_discNumber = p2;
						next_curRecord = FIRST_REC;
					end
				end else if (cmd == CMD_CLOSE) begin
					if (!fileOpen) begin
						next_cmdResult = ERR_NOT_OPEN;
					end else begin
						next_fileOpen = 1'b0;
					end
				end else if (cmd == CMD_RENAME) begin
					if (fileOpen) begin
						next_cmdResult = ERR_NOT_OPEN;
					end else begin
						next_mbRe = 1'b1;
						next_mbAddr = slotBase + OFS_NAME;
						next_retState = S_NM_CAP;
						next_state = S_WAIT;
					end
				end else if (cmd != CMD_ADVANCE && cmd != CMD_BACKUP && cmd != CMD_POSITION
						&& cmd != CMD_READ && cmd != CMD_REWIND && cmd != CMD_WRITE) begin
					next_cmdResult = ERR_BAD_CODE;
				end else if (!fileOpen) begin
					next_cmdResult = ERR_NOT_OPEN;
				end else if (cmd == CMD_ADVANCE) begin
					if (advSum > {1'b0, lastRecord + FIRST_REC}) begin
						next_cmdResult = ERR_RANGE;
					end else begin
						next_curRecord = advSum[14:0];
					end
				end else if (cmd == CMD_BACKUP) begin
					if (count15 >= curRecord) begin
						next_cmdResult = ERR_RANGE;
					end else begin
						next_curRecord = curRecord - count15;
					end
				end else if (cmd == CMD_POSITION) begin
					if (count15 < FIRST_REC || count15 > lastRecord + FIRST_REC) begin
						next_cmdResult = ERR_RANGE;
					end else begin
						next_curRecord = count15;
					end
				end else if (cmd == CMD_REWIND) begin
					next_curRecord = FIRST_REC;
				end else if (cmd == CMD_READ) begin
					if (curRecord < FIRST_REC || curRecord > lastRecord) begin
						next_cmdResult = ERR_RANGE;
					end else begin
						next_xferLen = (p1 < stLenRd) ? p1 : stLenRd;
						next_state = (p1 == 8'h00 || stLenRd == 8'h00) ? S_RD_CNT
							: S_RD_FETCH;
					end
				end else begin
					if (p1 > MAX_WORDS) begin
						next_cmdResult = ERR_LENGTH;
					end else if (curRecord > lastRecord + FIRST_REC
							|| curRecord > REC_CAPACITY) begin
						next_cmdResult = ERR_RANGE;
					end else if (p1 == 8'h00) begin
						stLenWe = 1'b1;
						next_lastRecord = curRecord;
						next_curRecord = curRecord + FIRST_REC;
					end else begin
						next_mbRe = 1'b1;
						next_mbAddr = slotBase + OFS_DATA;
						next_retState = S_WR_CAP;
						next_state = S_WAIT;
					end
				end
			end
			S_WR_CAP: begin
				// Even byte is the high half of a word, odd byte completes it
				if (!idx[0]) begin
					next_hiByte = mbRdData;
				end else begin
					stWordWe = 1'b1;
				end
				if (idx == wrLastByte) begin
					stLenWe = 1'b1;
					next_lastRecord = curRecord;
					next_curRecord = curRecord + FIRST_REC;
					next_state = S_FINISH;
				end else begin
					next_idx = idx + 9'h001;
					next_mbRe = 1'b1;
					next_mbAddr = slotBase + OFS_DATA + {7'h00, idx + 9'h001};
					next_retState = S_WR_CAP;
					next_state = S_WAIT;
				end
			end
			S_RD_FETCH: begin
				next_state = S_RD_HI;
			end
			S_RD_HI: begin
				next_mbWe = 1'b1;
				next_mbWrData = stRdData[15:8];
				next_mbAddr = slotBase + OFS_DATA + {7'h00, idx};
				next_idx = idx + 9'h001;
				next_retState = S_RD_LO;
				next_state = S_WAIT;
			end
			S_RD_LO: begin
				next_mbWe = 1'b1;
				next_mbWrData = stRdData[7:0];
				next_mbAddr = slotBase + OFS_DATA + {7'h00, idx};
				next_idx = idx + 9'h001;
				next_retState = (idx == rdLastByte) ? S_RD_CNT : S_RD_FETCH;
				next_state = S_WAIT;
			end
			S_RD_CNT: begin
				next_mbWe = 1'b1;
				next_mbWrData = xferLen;
				next_mbAddr = slotBase + OFS_P1;
				next_curRecord = curRecord + FIRST_REC;
				next_retState = S_FINISH;
				next_state = S_WAIT;
			end
			S_NM_CAP: begin
				next_nameBuf = {nameBuf[119:0], mbRdData};
				if (idx == NAME_LAST_BYTE) begin
					// Header sits in the top byte once all sixteen are in
					if (next_nameBuf[127-7+NAME_ZERO_MSB:120] != 3'h0
							|| next_nameBuf[120+NAME_LEN_MSB:120+NAME_LEN_LSB]
							> NAME_LEN_MAX) begin
						next_cmdResult = ERR_NAME;
					end else begin
						next_nameRecord = next_nameBuf;
						next_nameUpdated = 1'b1;
					end
					next_state = S_FINISH;
				end else begin
					next_idx = idx + 9'h001;
					next_mbRe = 1'b1;
					next_mbAddr = slotBase + OFS_NAME + {7'h00, idx + 9'h001};
					next_retState = S_NM_CAP;
					next_state = S_WAIT;
				end
			end
			S_FINISH: begin
				// Result clears bit 7, so the same store never runs twice
				next_mbWe = 1'b1;
				next_mbWrData = cmdResult;
				next_mbAddr = slotBase + OFS_CMD;
				next_cmdDone = 1'b1;
				next_retState = S_IDLE;
				next_state = S_WAIT;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= S_IDLE;
			retState <= S_IDLE;
			cmd <= 8'h00;
			p1 <= 8'h00;
			p2 <= 8'h00;
			idx <= 9'h000;
			hiByte <= 8'h00;
			xferLen <= 8'h00;
			cmdResult <= RES_OK;
			mbAddr <= 16'h0000;
			mbWrData <= 8'h00;
			mbRe <= 1'b0;
			mbWe <= 1'b0;
			cmdDone <= 1'b0;
			nameUpdated <= 1'b0;
			fileOpen <= 1'b0;
			fileType <= 8'h00;
			discNumber <= 8'h00;
			curRecord <= FIRST_REC;
			lastRecord <= EMPTY_REC;
			nameBuf <= 128'h0;
			nameRecord <= 128'h0;
		end else begin
			state <= next_state;
			retState <= next_retState;
			cmd <= next_cmd;
			p1 <= next_p1;
			p2 <= next_p2;
			idx <= next_idx;
			hiByte <= next_hiByte;
			xferLen <= next_xferLen;
			cmdResult <= next_cmdResult;
			mbAddr <= next_mbAddr;
			mbWrData <= next_mbWrData;
			mbRe <= next_mbRe;
			mbWe <= next_mbWe;
			cmdDone <= next_cmdDone;
			nameUpdated <= next_nameUpdated;
			fileOpen <= next_fileOpen;
			fileType <= next_fileType;
			discNumber <= next_discNumber;
			curRecord <= next_curRecord;
			lastRecord <= next_lastRecord;
			nameBuf <= next_nameBuf;
			nameRecord <= next_nameRecord;
		end
	end

	// Busy whenever a command is in flight
	assign busy = (state != S_IDLE);
endmodule

// [verilog/dcrm_pkg.sv]
// Shared constants of the disc record mailbox handler
package dcrm_pkg;

	// ------------------------------------------------------------
	// Command codes stored into the command byte
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_OPEN    = 8'h81;
	localparam logic [7:0] CMD_CLOSE   = 8'h82;
	localparam logic [7:0] CMD_ADVANCE = 8'h84;
	localparam logic [7:0] CMD_BACKUP  = 8'h85;
	localparam logic [7:0] CMD_POSITION = 8'h86;
	localparam logic [7:0] CMD_READ    = 8'h87;
	localparam logic [7:0] CMD_REWIND  = 8'h88;
	localparam logic [7:0] CMD_WRITE   = 8'h89;
	localparam logic [7:0] CMD_RENAME  = 8'h8a;
	localparam int         CMD_REQ_BIT = 7;

	// ------------------------------------------------------------
	// Result codes written back into the command byte
	// ------------------------------------------------------------
	localparam logic [7:0] RES_OK       = 8'h00;
	localparam logic [7:0] ERR_RANGE    = 8'h03;
	localparam logic [7:0] ERR_NOT_OPEN = 8'h09;
	localparam logic [7:0] ERR_BAD_CODE = 8'h0a;
	localparam logic [7:0] ERR_LENGTH   = 8'h0c;
	localparam logic [7:0] ERR_NAME     = 8'h0f;

	// ------------------------------------------------------------
	// Mailbox layout, byte offsets from the command byte slot
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_CMD  = 16'h0000;
	localparam logic [15:0] OFS_P1   = 16'h0001;
	localparam logic [15:0] OFS_P2   = 16'h0002;
	localparam logic [15:0] OFS_DATA = 16'h0002;
	localparam logic [15:0] OFS_NAME = 16'h0001;
	localparam logic [8:0]  NAME_LAST_BYTE = 9'h00f;

	// ------------------------------------------------------------
	// Record store geometry and pointer values
	// ------------------------------------------------------------
	localparam logic [7:0]  MAX_WORDS = 8'h80;
	localparam int          REC_AW    = 4;
	localparam int          WORD_AW   = 7;
	localparam logic [14:0] REC_CAPACITY = 15'h0010;
	localparam logic [14:0] FIRST_REC = 15'h0001;
	localparam logic [14:0] EMPTY_REC = 15'h0000;

	// ------------------------------------------------------------
	// Name header fields
	// ------------------------------------------------------------
	localparam int         NAME_LEN_MSB  = 7;
	localparam int         NAME_LEN_LSB  = 5;
	localparam logic [2:0] NAME_LEN_MAX  = 3'h4;
	localparam int         NAME_ZERO_MSB = 2;

	// ------------------------------------------------------------
	// Polling timing
	// ------------------------------------------------------------
	localparam int         MCLK_MHZ    = 250;
	localparam int         POLL_NS     = 1000;
	localparam int         POLL_CYCLES = (POLL_NS * MCLK_MHZ) / 1000;
	localparam logic [9:0] POLL_LAST   = 10'(POLL_CYCLES - 1);

endpackage

// [verilog/dcrm_poll_timer.sv]
// Periodic poll tick generator for the mailbox command byte
`timescale 1ns/100ps
module dcrm_poll_timer (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// Tick out
	output logic      pollTick
);
	import dcrm_pkg::*;

	logic [9:0] count;
	logic [9:0] next_count;
	logic       next_pollTick;

	// Free running count, one tick per poll period
	always_comb begin
		next_pollTick = (count == POLL_LAST);
		next_count = next_pollTick ? 10'h000 : count + 10'h001;
	end

	// Registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			count <= 10'h000;
			pollTick <= 1'b0;
		end else begin
			count <= next_count;
			pollTick <= next_pollTick;
		end
	end
endmodule

// [verilog/dcrm_rec_store.sv]
// Record word store and record length table
`timescale 1ns/100ps
module dcrm_rec_store (
	// Clock and reset
	input  wire logic                                     mclk,
	input  wire logic                                     sys_rst,
	// Word write
	input  wire logic                                     wordWe,
	input  wire logic [dcrm_pkg::REC_AW+dcrm_pkg::WORD_AW-1:0] wordAddr,
	input  wire logic [15:0]                              wordWrData,
	// Word read, one cycle latency
	output logic      [15:0]                              wordRdData,
	// Length table
	input  wire logic                                     lenWe,
	input  wire logic [dcrm_pkg::REC_AW-1:0]              lenIdx,
	input  wire logic [7:0]                               lenWrData,
	output logic      [7:0]                               lenRdData
);
	import dcrm_pkg::*;

	localparam int DEPTH = 1 << (REC_AW + WORD_AW);
	localparam int RECS  = 1 << REC_AW;

	logic [15:0] words [DEPTH];
	logic [7:0]  lens  [RECS];

	// Word array, written and read on the same address port
	always_ff @(posedge mclk) begin
		if (wordWe) begin
			words[wordAddr] <= wordWrData;
		end
		wordRdData <= words[wordAddr];
	end

	// Length table, cleared at reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int i = 0; i < RECS; i++) begin
				lens[i] <= 8'h00;
			end
		end else if (lenWe) begin
			lens[lenIdx] <= lenWrData;
		end
	end

	assign lenRdData = lens[lenIdx];
endmodule

// [verification/dcrm_mem_model.sv]
// Mailbox memory shared by the target program and the handler
`timescale 1ns/100ps
module dcrm_mem_model (
	// Clock
	input  wire logic        mclk,
	// Handler side
	input  wire logic [15:0] mbAddr,
	input  wire logic        mbRe,
	input  wire logic        mbWe,
	input  wire logic [7:0]  mbWrData,
	output logic      [7:0]  mbRdData
);
	// Byte array, loaded by the bench in the program's place
	logic [7:0] mem [0:65535];

	// Start from a cleared mailbox
	initial begin
		mbRdData = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
	end

	// Data shows one cycle after the strobe, then turns over every cycle
	always @(posedge mclk) begin
		if (mbRe) begin
			mbRdData <= mem[mbAddr];
		end else begin
			mbRdData <= ~mbRdData;
		end
		if (mbWe) begin
			mem[mbAddr] <= mbWrData;
		end
	end
endmodule

// [verification/dcrm_handler_props.sv]
// Port assertions of the mailbox command handler
`timescale 1ns/100ps
module dcrm_handler_props (
	// Clock and reset
	input wire logic         mclk,
	input wire logic         sys_rst,
	// Mailbox port
	input wire logic [15:0]  slotBase,
	input wire logic [15:0]  mbAddr,
	input wire logic         mbRe,
	input wire logic         mbWe,
	input wire logic [7:0]   mbWrData,
	input wire logic [7:0]   mbRdData,
	// Status
	input wire logic         fileOpen,
	input wire logic [7:0]   fileType,
	input wire logic [7:0]   discNumber,
	input wire logic [14:0]  curRecord,
	input wire logic [14:0]  lastRecord,
	input wire logic         busy,
	input wire logic         cmdDone,
	input wire logic [7:0]   cmdResult,
	input wire logic [127:0] nameRecord,
	input wire logic         nameUpdated
);
	import dcrm_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// Steps of one command: poll read, then result write
	sequence pollRead;
		mbRe && mbAddr == slotBase;
	endsequence
	sequence resultWrite;
		mbWe && mbAddr == slotBase && cmdDone;
	endsequence

	result_write_a: assert property (cmdDone |-> resultWrite)
		else $error("result not written to the command byte");
	result_clear_a: assert property (cmdDone |-> !mbWrData[CMD_REQ_BIT])
		else $error("result carries the request bit");
	strobe_gap_a: assert property ((mbRe || mbWe) |=> !(mbRe || mbWe))
		else $error("mailbox accesses too close");
	poll_slot_a: assert property ($rose(busy) |-> ##[0:1] pollRead)
		else $error("command not started by a slot poll");
	done_idle_a: assert property (cmdDone |=> !busy)
		else $error("busy after the result");
	idle_quiet_a: assert property (!busy |-> !mbWe)
		else $error("write while idle");
	open_first_a: assert property ($rose(fileOpen) |-> ##[0:2] curRecord == FIRST_REC)
		else $error("open did not select record one");
	last_next_a: assert property ((lastRecord != $past(lastRecord))
		|-> ##[0:4] (curRecord == lastRecord + 15'h0001))
		else $error("pointer not past the new last record");
	closed_frozen_a: assert property ((!fileOpen && !$past(fileOpen)) |-> $stable(lastRecord))
		else $error("file changed while closed");
	rename_closed_a: assert property (nameUpdated |-> !fileOpen)
		else $error("rename accepted while open");
endmodule

bind dcrm_handler dcrm_handler_props chk_u (.mclk, .sys_rst, .slotBase, .mbAddr, .mbRe,
	.mbWe, .mbWrData, .mbRdData, .fileOpen, .fileType, .discNumber, .curRecord,
	.lastRecord, .busy, .cmdDone, .cmdResult, .nameRecord, .nameUpdated);

// [verification/dcrm_handler_test.sv]
// Self-checking bench of the mailbox command handler
`timescale 1ns/100ps
module dcrm_handler_test;
	import dcrm_pkg::*;
	localparam logic [15:0] BASE = 16'h1000;
	logic         mclk, sys_rst, mbRe, mbWe, fileOpen, busy, cmdDone, nameUpdated;
	logic [15:0]  slotBase, mbAddr;
	logic [7:0]   mbWrData, mbRdData, fileType, discNumber, cmdResult;
	logic [14:0]  curRecord, lastRecord;
	logic [127:0] nameRecord, expName;
	int           fails, samples_checked;

	// ----------------------------------------
	// Design, mailbox memory and clock
	// ----------------------------------------
	dcrm_handler dut_u (.mclk, .sys_rst, .slotBase, .mbAddr, .mbRe, .mbWe, .mbWrData,
		.mbRdData, .fileOpen, .fileType, .discNumber, .curRecord, .lastRecord, .busy,
		.cmdDone, .cmdResult, .nameRecord, .nameUpdated);
	dcrm_mem_model mem_u (.mclk, .mbAddr, .mbRe, .mbWe, .mbWrData, .mbRdData);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic poke(input int ofs, input logic [7:0] v);
		mem_u.mem[BASE + 16'(ofs)] = v;
	endtask
	function automatic logic [7:0] peek(input int ofs);
		return mem_u.mem[BASE + 16'(ofs)];
	endfunction
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Store the code after the parameters, wait for the answer, check it
	task automatic go(input logic [7:0] code, input logic [7:0] exp);
		int i;
		@(negedge mclk);
		poke(0, code);
		for (i = 0; i < 4000 && cmdDone !== 1'b1; i++) @(negedge mclk);
		if (i == 4000) begin
			fails++;
			tally_and_finish();
		end
		@(negedge mclk);
		chk(peek(0), exp);
		chk(cmdResult, exp);
	endtask
	task automatic cmd(input logic [7:0] code, p1, p2, exp);
		poke(1, p1);
		poke(2, p2);
		go(code, exp);
	endtask
	// Record r of n words: high byte r, low byte word index
	task automatic putRec(input int r, input int n);
		poke(1, 8'(n));
		for (int k = 0; k < n; k++) begin
			poke(2 + 2 * k, 8'(r));
			poke(3 + 2 * k, 8'(k));
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_closed();
		chk({fileOpen, busy, curRecord, lastRecord}, {2'b00, 15'h0001, 15'h0000});
		cmd(CMD_ADVANCE, 8'h01, 8'h00, ERR_NOT_OPEN);
		go(CMD_READ, ERR_NOT_OPEN);
		go(CMD_CLOSE, ERR_NOT_OPEN);
		poke(0, 8'h05);
		repeat (600) @(negedge mclk);
		chk(peek(0), 8'h05);
		go(8'h8b, ERR_BAD_CODE);
	endtask
	task automatic t_write();
		cmd(CMD_OPEN, 8'h0a, 8'h03, RES_OK);
		chk({fileOpen, fileType, discNumber, curRecord}, {1'b1, 16'h0a03, 15'h0001});
		putRec(1, 2);
		go(CMD_WRITE, RES_OK);
		putRec(2, 128);
		go(CMD_WRITE, RES_OK);
		putRec(3, 1);
		go(CMD_WRITE, RES_OK);
		chk({curRecord, lastRecord}, {15'h0004, 15'h0003});
		poke(1, 8'h81);
		go(CMD_WRITE, ERR_LENGTH);
		chk(lastRecord, 3);
	endtask
	task automatic t_select();
		cmd(CMD_POSITION, 8'h02, 8'h80, RES_OK);
		chk(curRecord, 2);
		cmd(CMD_ADVANCE, 8'h02, 8'h00, RES_OK);
		chk(curRecord, 4);
		cmd(CMD_ADVANCE, 8'h01, 8'h00, ERR_RANGE);
		cmd(CMD_BACKUP, 8'h03, 8'h00, RES_OK);
		chk(curRecord, 1);
		cmd(CMD_BACKUP, 8'h01, 8'h00, ERR_RANGE);
		cmd(CMD_POSITION, 8'h05, 8'h00, ERR_RANGE);
		cmd(CMD_POSITION, 8'h03, 8'h00, RES_OK);
		go(CMD_REWIND, RES_OK);
		chk(curRecord, 1);
	endtask
	task automatic t_read();
		for (int b = 2; b < 6; b++) begin
			poke(b, 8'hee);
		end
		poke(1, MAX_WORDS);
		go(CMD_READ, RES_OK);
		chk({peek(1), peek(2), peek(3), peek(4), peek(5)}, 40'h02_0100_0101);
		poke(1, 8'h01);
		poke(2, 8'hee);
		go(CMD_READ, RES_OK);
		chk({peek(1), peek(2), peek(3), curRecord}, {24'h010200, 15'h0003});
		cmd(CMD_POSITION, 8'h02, 8'h00, RES_OK);
		putRec(7, 1);
		go(CMD_WRITE, RES_OK);
		chk({curRecord, lastRecord}, {15'h0003, 15'h0002});
		poke(1, MAX_WORDS);
		go(CMD_READ, ERR_RANGE);
		poke(1, 8'h00);
		go(CMD_WRITE, RES_OK);
		chk({curRecord, lastRecord}, {15'h0004, 15'h0003});
		cmd(CMD_POSITION, 8'h03, 8'h00, RES_OK);
		poke(1, MAX_WORDS);
		go(CMD_READ, RES_OK);
		chk(peek(1), 8'h00);
	endtask
	task automatic t_rename();
		go(CMD_RENAME, ERR_NOT_OPEN);
		go(CMD_CLOSE, RES_OK);
		chk(fileOpen, 0);
		for (int i = 1; i <= 16; i++) begin
			poke(i, (i == 1) ? 8'h50 : 8'(8'h40 + i));
			expName[135 - 8 * i -: 8] = (i == 1) ? 8'h50 : 8'(8'h40 + i);
		end
		go(CMD_RENAME, RES_OK);
		chk(nameRecord, expName);
		chk(fileOpen, 0);
		poke(1, 8'h51);
		go(CMD_RENAME, ERR_NAME);
		poke(1, 8'ha0);
		go(CMD_RENAME, ERR_NAME);
		chk(nameRecord, expName);
		cmd(CMD_OPEN, 8'h0a, 8'h00, RES_OK);
		chk({curRecord, lastRecord}, {15'h0001, 15'h0003});
		cmd(CMD_OPEN, 8'h0a, 8'h00, ERR_NOT_OPEN);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		fails = 0;
		samples_checked = 0;
		expName = '0;
		slotBase = BASE;
		sys_rst = 1'b1;
		repeat (6) @(negedge mclk);
		sys_rst = 1'b0;
		t_closed();
		t_write();
		t_select();
		t_read();
		t_rename();
		tally_and_finish();
	end
endmodule
